/* File: rtl/abmi_bus_if.sv */
// Shared bus wires between the master and the slave/alternate master
`timescale 1ns/10ps
interface abmi_bus_if
  import abmi_pkg::*;
  ();

  // Master drives
  logic [ABMI_ADDR_W-1:0] m_addr;
  logic m_addr_oe;
  logic [ABMI_DATA_W-1:0] m_data;
  logic m_data_oe;
  logic m_as_b;
  logic m_upper_stb_b;
  logic m_lower_stb_b;
  logic m_rw;
  logic m_ctrl_oe;
  logic m_grant_b;

  // Far end drives
  logic [ABMI_DATA_W-1:0] s_data;
  logic s_data_oe;
  logic s_ack_b;
  logic s_req_oe;
  logic s_gack_oe;

  // Resolved wire levels
  logic [ABMI_ADDR_W-1:0] addr;
  logic [ABMI_DATA_W-1:0] data;
  logic addr_valid_strobe_b;
  logic upper_byte_strobe_b;
  logic lower_byte_strobe_b;
  logic rw;
  logic transfer_ack_b;
  logic bus_request_in_b;
  logic bus_grant_out_b;
  logic bus_grant_ack_in_b;

  // Three-state lines fall back to pull-up level when released
  assign addr = m_addr_oe ? m_addr : {ABMI_ADDR_W{1'b1}};
  assign data = m_data_oe ? m_data : (s_data_oe ? s_data : ABMI_BUS_IDLE);
  assign addr_valid_strobe_b = m_ctrl_oe ? m_as_b : 1'b1;
  assign upper_byte_strobe_b = m_ctrl_oe ? m_upper_stb_b : 1'b1;
  assign lower_byte_strobe_b = m_ctrl_oe ? m_lower_stb_b : 1'b1;
  assign rw = m_ctrl_oe ? m_rw : 1'b1;
  assign transfer_ack_b = s_ack_b;
  // Open-drain request and grant acknowledge
  assign bus_request_in_b = ~s_req_oe;
  assign bus_grant_ack_in_b = ~s_gack_oe;
  assign bus_grant_out_b = m_grant_b;

  modport master (
    output m_addr, m_addr_oe, m_data, m_data_oe, m_as_b, m_upper_stb_b,
    output m_lower_stb_b, m_rw, m_ctrl_oe, m_grant_b,
    input data, transfer_ack_b, bus_request_in_b, bus_grant_ack_in_b
  );

  modport slave (
    output s_data, s_data_oe, s_ack_b, s_req_oe, s_gack_oe,
    input addr, data, addr_valid_strobe_b, upper_byte_strobe_b,
    input lower_byte_strobe_b, rw, bus_grant_out_b, bus_grant_ack_in_b,
    input transfer_ack_b
  );

endinterface : abmi_bus_if

/* File: rtl/abmi_master.sv */
// Processor end: asynchronous bus cycles and bus arbitration
//
// Summary of operation
// - Drive 23-bit word address for normal cycles.
// - Interrupt cycle: level low, upper lines high.
// - 16-bit three-state data path, words or bytes.
// - Interrupter returns vector on low byte lane.
// - Address strobe only while address is valid.
// - Read: line high, capture strobed lanes only.
// - Word write: line low, both lanes driven.
// - Byte write duplicates selected byte on both lanes.
// - Slave acknowledges; read latches data, ends cycle.
// - Write ends on recognised acknowledge.
// - Wired request line means another wants bus.
// - Answer request with grant, release after cycle.
// - No own cycles while grant acknowledge asserted.
// - Alternate takes bus only when all idle.
`timescale 1ns/10ps
module abmi_master
  import abmi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  abmi_bus_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_intack,
  input wire logic [ABMI_LEVEL_W-1:0] cmd_level,
  input wire logic [ABMI_ADDR_W-1:0] cmd_addr,
  input wire logic [1:0] cmd_be,
  input wire logic [ABMI_DATA_W-1:0] cmd_wdata,
  output logic rsp_done,
  output logic [ABMI_DATA_W-1:0] rsp_rdata,
  output logic ext_owner
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    abmi_mstate_type st;
    logic [ABMI_ADDR_W-1:0] addr;
    logic addr_oe;
    logic [ABMI_DATA_W-1:0] wdata;
    logic data_oe;
    logic as_b;
    logic upper_stb_b;
    logic lower_stb_b;
    logic rw;
    logic ctrl_oe;
    logic grant_b;
    logic [1:0] be;
    logic [ABMI_DATA_W-1:0] rdata;
    logic done;
    logic ready;
    logic owner;
  } abmi_mreg_type;

  localparam abmi_mreg_type ABMI_MREG_RESET = '{
    st: ABMI_IDLE,
    addr: {ABMI_ADDR_W{1'b0}},
    addr_oe: 1'b1,
    wdata: {ABMI_DATA_W{1'b0}},
    data_oe: 1'b0,
    as_b: 1'b1,
    upper_stb_b: 1'b1,
    lower_stb_b: 1'b1,
    rw: 1'b1,
    ctrl_oe: 1'b1,
    grant_b: 1'b1,
    be: 2'h0,
    rdata: {ABMI_DATA_W{1'b0}},
    done: 1'b0,
    ready: 1'b0,
    owner: 1'b0
  };

  abmi_mreg_type r;
  abmi_mreg_type next_r;

  logic bus_req;
  logic grant_ack;
  logic ack;
  logic start;

  ////////////////////////////////////////////////////////////////////////
  // Write lane steering

  // Single-byte writes copy the chosen byte onto both lanes
  function automatic logic [ABMI_DATA_W-1:0] abmi_write_lanes(
    input logic [1:0] be,
    input logic [ABMI_DATA_W-1:0] wd
  );
    logic [ABMI_DATA_W-1:0] res;
    res = wd;
    if (be == 2'h1) begin
      res = {wd[7:0], wd[7:0]};
    end else if (be == 2'h2) begin
      res = {wd[15:8], wd[15:8]};
    end
    return res;
  endfunction : abmi_write_lanes

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Active-low wire levels turned into assertion terms
  assign bus_req = ~bus.bus_request_in_b;
  assign grant_ack = ~bus.bus_grant_ack_in_b;
  assign ack = ~bus.transfer_ack_b;
  // Ready was only offered with the bus free and no grant out
  assign start = cmd_valid & r.ready;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.owner = grant_ack;
    // Release every three-state line while another master owns the bus
    next_r.addr_oe = ~grant_ack;
    next_r.ctrl_oe = ~grant_ack;

    unique case (r.st)
      ABMI_IDLE: begin
        if (start) begin
          // Interrupt cycles carry the level, not an address
          if (cmd_intack) begin
            next_r.addr = {ABMI_INT_ADDR_HIGH, cmd_level};
            next_r.be = ABMI_INTACK_BE;
            next_r.rw = 1'b1;
          end else begin
            next_r.addr = cmd_addr;
            next_r.be = cmd_be;
            next_r.rw = ~cmd_write;
          end
          next_r.wdata = abmi_write_lanes(cmd_be, cmd_wdata);
          next_r.st = ABMI_SETUP;
        end
      end
      ABMI_SETUP: begin
        // One cycle of address settling before the strobe
        next_r.as_b = 1'b0;
        next_r.upper_stb_b = ~r.be[ABMI_UPPER_LANE];
        next_r.lower_stb_b = ~r.be[ABMI_LOWER_LANE];
        next_r.data_oe = ~r.rw;
        next_r.st = ABMI_STROBE;
      end
      ABMI_STROBE: begin
        // Wait cycles are inserted for as long as the slave needs
        if (ack) begin
          if (r.rw) begin
            next_r.rdata = {
              r.be[ABMI_UPPER_LANE] ? bus.data[15:8] : ABMI_BYTE_ZERO,
              r.be[ABMI_LOWER_LANE] ? bus.data[7:0] : ABMI_BYTE_ZERO
            };
          end
          next_r.as_b = 1'b1;
          next_r.upper_stb_b = 1'b1;
          next_r.lower_stb_b = 1'b1;
          next_r.done = 1'b1;
          next_r.st = ABMI_END;
        end
      end
      ABMI_END: begin
        // Write data held past the strobes, then released
        next_r.data_oe = 1'b0;
        next_r.rw = 1'b1;
        // Next cycle waits for the slave to drop its acknowledge
        if (!ack) begin
          next_r.st = ABMI_IDLE;
        end
      end
    endcase

    // Arbitration; a grant is never raised in the strobe-free setup gap
    if (grant_ack) begin
      next_r.grant_b = 1'b1;
    end else if (bus_req && !(r.st == ABMI_IDLE && start) &&
                 r.st != ABMI_SETUP) begin
      next_r.grant_b = 1'b0;
    end else if (!bus_req) begin
      next_r.grant_b = 1'b1;
    end

    // Data enable kept in its own flop so the pin needs no gating
    if (grant_ack) begin
      next_r.data_oe = 1'b0;
    end

    // Offer a new cycle only with the bus ours and nobody asking
    next_r.ready = (next_r.st == ABMI_IDLE) && !start && next_r.grant_b &&
                   r.grant_b && !grant_ack && !bus_req;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= ABMI_MREG_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign bus.m_addr = r.addr;
  assign bus.m_addr_oe = r.addr_oe;
  assign bus.m_data = r.wdata;
  assign bus.m_data_oe = r.data_oe;
  assign bus.m_as_b = r.as_b;
  assign bus.m_upper_stb_b = r.upper_stb_b;
  assign bus.m_lower_stb_b = r.lower_stb_b;
  assign bus.m_rw = r.rw;
  assign bus.m_ctrl_oe = r.ctrl_oe;
  assign bus.m_grant_b = r.grant_b;
  assign cmd_ready = r.ready;
  assign rsp_done = r.done;
  assign rsp_rdata = r.rdata;
  assign ext_owner = r.owner;

endmodule : abmi_master

/* File: rtl/abmi_pkg.sv */
// Shared constants and state codes for the asynchronous bus master link
package abmi_pkg;

  // Bus widths
  localparam int ABMI_ADDR_W = 23;
  localparam int ABMI_DATA_W = 16;
  localparam int ABMI_LEVEL_W = 3;

  // Interrupt cycle: lines above the level field all driven high
  localparam logic [19:0] ABMI_INT_ADDR_HIGH = 20'hFFFFF;
  // Level of an undriven data bus (pull-ups)
  localparam logic [15:0] ABMI_BUS_IDLE = 16'hFFFF;
  // Lane positions
  localparam int ABMI_UPPER_LANE = 1;
  localparam int ABMI_LOWER_LANE = 0;
  // Byte enables of an interrupt acknowledge: lower lane only
  localparam logic [1:0] ABMI_INTACK_BE = 2'h1;
  localparam logic [7:0] ABMI_BYTE_ZERO = 8'h00;

  // Defaults of the far end
  localparam int ABMI_WAIT_DEFAULT = 2;
  localparam int ABMI_MEM_AW_DEFAULT = 8;
  localparam logic [7:0] ABMI_CNT_ZERO = 8'h00;
  localparam logic [7:0] ABMI_CNT_ONE = 8'h01;

  // Master cycle sequencer
  typedef enum logic [3:0] {
    ABMI_IDLE = 4'h1,
    ABMI_SETUP = 4'h2,
    ABMI_STROBE = 4'h4,
    ABMI_END = 4'h8
  } abmi_mstate_type;

  // Slave responder
  typedef enum logic [2:0] {
    ABMI_S_IDLE = 3'h1,
    ABMI_S_WAIT = 3'h2,
    ABMI_S_ACK = 3'h4
  } abmi_sstate_type;

endpackage : abmi_pkg

/* File: rtl/abmi_slave.sv */
// Far end: memory slave, interrupt vector source and alternate master
`timescale 1ns/10ps
module abmi_slave
  import abmi_pkg::*;
#(
  parameter int WAIT_CYCLES = ABMI_WAIT_DEFAULT,
  parameter int MEM_AW = ABMI_MEM_AW_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  abmi_bus_if.slave bus,
  input wire logic [7:0] int_vector,
  input wire logic alt_req,
  output logic alt_owns
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    abmi_sstate_type st;
    logic [7:0] cnt;
    logic ack_b;
    logic [ABMI_DATA_W-1:0] dout;
    logic dout_oe;
    logic req_oe;
    logic gack_oe;
  } abmi_sreg_type;

  localparam abmi_sreg_type ABMI_SREG_RESET = '{
    st: ABMI_S_IDLE,
    cnt: 8'h00,
    ack_b: 1'b1,
    dout: {ABMI_DATA_W{1'b0}},
    dout_oe: 1'b0,
    req_oe: 1'b0,
    gack_oe: 1'b0
  };
  localparam logic [7:0] ABMI_WAIT_CNT = 8'(WAIT_CYCLES);

  abmi_sreg_type r;
  abmi_sreg_type next_r;
  // Word store; no reset, contents are data not control
  logic [ABMI_DATA_W-1:0] mem [2**MEM_AW];

  logic as;
  logic any_strobe;
  logic int_cycle;
  logic fire;
  logic [MEM_AW-1:0] idx;

  assign as = ~bus.addr_valid_strobe_b;
  assign any_strobe = ~bus.upper_byte_strobe_b | ~bus.lower_byte_strobe_b;
  assign int_cycle =
    bus.addr[ABMI_ADDR_W-1:ABMI_LEVEL_W] == ABMI_INT_ADDR_HIGH;
  assign fire = (r.st == ABMI_S_WAIT) && (r.cnt == ABMI_CNT_ZERO);
  assign idx = bus.addr[MEM_AW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Responder and arbitration

  always_comb begin
    next_r = r;
    unique case (r.st)
      ABMI_S_IDLE: begin
        if (as && any_strobe) begin
          next_r.cnt = ABMI_WAIT_CNT;
          next_r.st = ABMI_S_WAIT;
        end
      end
      ABMI_S_WAIT: begin
        if (r.cnt == ABMI_CNT_ZERO) begin
          next_r.ack_b = 1'b0;
          next_r.dout_oe = bus.rw;
          if (int_cycle) begin
            next_r.dout = {ABMI_BYTE_ZERO, int_vector};
          end else begin
            next_r.dout = mem[idx];
          end
          next_r.st = ABMI_S_ACK;
        end else begin
          next_r.cnt = r.cnt - ABMI_CNT_ONE;
        end
      end
      ABMI_S_ACK: begin
        // Acknowledge held until the master drops its strobe
        if (!as) begin
          next_r.ack_b = 1'b1;
          next_r.dout_oe = 1'b0;
          next_r.st = ABMI_S_IDLE;
        end
      end
    endcase

    // Alternate master: request, then claim only a quiet bus
    if (r.gack_oe) begin
      next_r.req_oe = 1'b0;
      next_r.gack_oe = alt_req;
    end else begin
      next_r.req_oe = alt_req;
      if (alt_req && !bus.bus_grant_out_b && bus.addr_valid_strobe_b &&
          bus.transfer_ack_b && bus.bus_grant_ack_in_b) begin
        next_r.gack_oe = 1'b1;
        next_r.req_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= ABMI_SREG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Byte-lane writes into the store
  always_ff @(posedge core_clk) begin
    if (fire && !bus.rw && !int_cycle) begin
      if (!bus.upper_byte_strobe_b) begin
        mem[idx][15:8] <= bus.data[15:8];
      end
      if (!bus.lower_byte_strobe_b) begin
        mem[idx][7:0] <= bus.data[7:0];
      end
    end
  end

  assign bus.s_data = r.dout;
  assign bus.s_data_oe = r.dout_oe;
  assign bus.s_ack_b = r.ack_b;
  assign bus.s_req_oe = r.req_oe;
  assign bus.s_gack_oe = r.gack_oe;
  assign alt_owns = r.gack_oe;

endmodule : abmi_slave

/* File: verif/abmi_link_props.sv */
// Concurrent checks on the shared bus wires between the two ends
`timescale 1ns/10ps
module abmi_link_props
  import abmi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ABMI_ADDR_W-1:0] addr,
  input wire logic [ABMI_DATA_W-1:0] data,
  input wire logic addr_valid_strobe_b,
  input wire logic upper_byte_strobe_b,
  input wire logic lower_byte_strobe_b,
  input wire logic rw,
  input wire logic transfer_ack_b,
  input wire logic bus_request_in_b,
  input wire logic bus_grant_out_b,
  input wire logic bus_grant_ack_in_b,
  input wire logic m_addr_oe,
  input wire logic m_ctrl_oe,
  input wire logic m_data_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  // Strobe qualifies address, direction and data
  a_addr_steady: assert property (
    !addr_valid_strobe_b && !$past(addr_valid_strobe_b)
    |-> $stable(addr) && m_addr_oe)
    else $error("address moved under strobe");
  a_rw_steady: assert property (
    !addr_valid_strobe_b && !$past(addr_valid_strobe_b) |-> $stable(rw))
    else $error("direction moved under strobe");
  a_write_drive: assert property (
    !addr_valid_strobe_b && !transfer_ack_b && !rw |-> m_data_oe)
    else $error("write data not driven at ack");
  // Single byte writes copy the byte to the idle lane
  a_byte_dup: assert property (
    !addr_valid_strobe_b && !transfer_ack_b && !rw &&
    (upper_byte_strobe_b != lower_byte_strobe_b)
    |-> data[15:8] == data[7:0])
    else $error("byte not duplicated on both lanes");
  ////////////////////////////////////////////////////////////////////////
  // Cycle stretches until ack, then ends one edge later
  a_hold_strobe: assert property (
    !addr_valid_strobe_b && transfer_ack_b
    |=> !addr_valid_strobe_b && !(upper_byte_strobe_b && lower_byte_strobe_b))
    else $error("strobe dropped before ack");
  a_end_on_ack: assert property (
    !addr_valid_strobe_b && !transfer_ack_b
    |=> addr_valid_strobe_b && upper_byte_strobe_b && lower_byte_strobe_b)
    else $error("cycle not ended after ack");
  ////////////////////////////////////////////////////////////////////////
  // Arbitration handshake
  a_grant_reply: assert property (
    $fell(bus_request_in_b) |-> ##[1:16] !bus_grant_out_b)
    else $error("no grant after request");
  a_owned_quiet: assert property (
    !bus_grant_ack_in_b && !$past(bus_grant_ack_in_b)
    |-> !m_addr_oe && !m_ctrl_oe && !m_data_oe)
    else $error("master drives while bus owned");
  a_grant_drop: assert property (
    !bus_grant_ack_in_b |=> bus_grant_out_b)
    else $error("grant held after grant ack");
  a_take_over: assert property (
    $fell(bus_grant_ack_in_b) |-> !$past(bus_grant_out_b) &&
    $past(addr_valid_strobe_b) && $past(transfer_ack_b))
    else $error("bus taken while busy or ungranted");
endmodule : abmi_link_props

/* File: verif/async_bus_master_interface_test.sv */
// Self-checking bench: master and far end joined by the shared bus
`timescale 1ns/10ps
module async_bus_master_interface_test
  import abmi_pkg::*;
();
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_write = 1'h0;
  logic cmd_intack = 1'h0;
  logic [2:0] cmd_level = 3'h0;
  logic [22:0] cmd_addr = 23'h0;
  logic [1:0] cmd_be = 2'h0;
  logic [15:0] cmd_wdata = 16'h0;
  logic [7:0] int_vector = 8'h00;
  logic alt_req = 1'h0;
  logic cmd_ready;
  logic rsp_done;
  logic ext_owner;
  logic alt_owns;
  logic [15:0] rsp_rdata;
  logic [22:0] seen_addr = 23'h0;
  int fails = 0;
  int n_checks = 0;
  ////////////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;
  abmi_bus_if bif ();
  abmi_master abmi_master_inst (.core_clk, .rst_b, .bus(bif), .cmd_valid,
    .cmd_ready, .cmd_write, .cmd_intack, .cmd_level, .cmd_addr, .cmd_be,
    .cmd_wdata, .rsp_done, .rsp_rdata, .ext_owner);
  abmi_slave #(.WAIT_CYCLES(2), .MEM_AW(8)) abmi_slave_inst (.core_clk,
    .rst_b, .bus(bif), .int_vector, .alt_req, .alt_owns);
  abmi_link_props abmi_link_props_inst (.core_clk, .rst_b,
    .addr(bif.addr), .data(bif.data),
    .addr_valid_strobe_b(bif.addr_valid_strobe_b),
    .upper_byte_strobe_b(bif.upper_byte_strobe_b),
    .lower_byte_strobe_b(bif.lower_byte_strobe_b), .rw(bif.rw),
    .transfer_ack_b(bif.transfer_ack_b),
    .bus_request_in_b(bif.bus_request_in_b),
    .bus_grant_out_b(bif.bus_grant_out_b),
    .bus_grant_ack_in_b(bif.bus_grant_ack_in_b),
    .m_addr_oe(bif.m_addr_oe), .m_ctrl_oe(bif.m_ctrl_oe),
    .m_data_oe(bif.m_data_oe));
  // Last address seen under the strobe, for address checks
  always @(posedge core_clk) begin
    if (bif.addr_valid_strobe_b === 1'h0) begin
      seen_addr <= bif.addr;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [22:0] got, input logic [22:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Bounded wait, so a stuck handshake shows as a mismatch
  task automatic wait_for(ref logic sig);
    for (int n = 0; n < 40 && sig !== 1'h1; n++) begin
      @(negedge core_clk);
    end
    check(sig, 1'h1);
  endtask : wait_for
  // One bus cycle; request held until the take edge has passed
  task automatic bus_op(input logic w, ia, input logic [2:0] lvl,
    input logic [22:0] a, input logic [1:0] be, input logic [15:0] wd);
    wait_for(cmd_ready);
    cmd_valid = 1'h1;
    cmd_write = w;
    cmd_intack = ia;
    cmd_level = lvl;
    cmd_addr = a;
    cmd_be = be;
    cmd_wdata = wd;
    @(negedge core_clk);
    cmd_valid = 1'h0;
    wait_for(rsp_done);
  endtask : bus_op
  task automatic rd(input logic [22:0] a, input logic [1:0] be,
    input logic [15:0] exp);
    bus_op(1'h0, 1'h0, 3'h0, a, be, 16'h0);
    check(rsp_rdata, exp);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    rst_b = 1'h1;
    bus_op(1'h1, 1'h0, 3'h0, 23'h6AAA10, 2'h3, 16'h1234);
    check(seen_addr, 23'h6AAA10);
    rd(23'h6AAA10, 2'h3, 16'h1234);
    $display("test word done");
    // Byte writes land in one lane only; unstrobed read lanes are zero
    bus_op(1'h1, 1'h0, 3'h0, 23'h11, 2'h3, 16'h5555);
    bus_op(1'h1, 1'h0, 3'h0, 23'h11, 2'h1, 16'h77CD);
    rd(23'h11, 2'h3, 16'h55CD);
    bus_op(1'h1, 1'h0, 3'h0, 23'h11, 2'h2, 16'hEE88);
    rd(23'h11, 2'h1, 16'h00CD);
    rd(23'h11, 2'h2, 16'hEE00);
    rd(23'h11, 2'h3, 16'hEECD);
    $display("test bytes done");
    // Interrupt acknowledge at each level from 1 to 7
    for (int l = 1; l < 8; l++) begin
      int_vector = 8'h40 + 8'(l);
      bus_op(1'h0, 1'h1, l[2:0], 23'h0, 2'h0, 16'h0);
      check(rsp_rdata, {8'h00, int_vector});
      check(seen_addr, {20'hFFFFF, l[2:0]});
    end
    $display("test intack done");
    // Alternate master takes the bus, then hands it back
    alt_req = 1'h1;
    wait_for(alt_owns);
    repeat (2) @(negedge core_clk);
    check(ext_owner, 1'h1);
    check(cmd_ready, 1'h0);
    check(bif.addr, 23'h7FFFFF);
    alt_req = 1'h0;
    rd(23'h6AAA10, 2'h3, 16'h1234);
    $display("test arbitration done");
    end_of_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule : async_bus_master_interface_test
